// *** audio_link_if.sv ***
/*
 * the serial audio link between a clock-driving source and the receiver.
 * assumes the source end drives every wire; the receiver only listens.
 */
`timescale 1ns/100ps
`default_nettype none
interface audio_link_if #(
	parameter int LINES = audio_port_pkg::LINES
);
	logic master_clock;
	logic bit_clock;
	logic frame_clock;
	logic [LINES-1:0] serial_data;

	modport device (
		input master_clock,
		input bit_clock,
		input frame_clock,
		input serial_data
	);

	modport host (
		output master_clock,
		output bit_clock,
		output frame_clock,
		output serial_data
	);
endinterface : audio_link_if
`default_nettype wire

// *** audio_link_properties.sv ***
/*
 * link checker: clock halves, frame length, duty and data timing on the audio wires.
 * assumes the source drives every wire from registers on clk and that resetn is the
 * source end's reset, so the first frame after any release is ignored as partial.
 */
`timescale 1ns/100ps
`default_nettype none
module audio_link_properties #(
	parameter int LINES = 2,
	parameter int BCLK_HALF = 16,
	parameter int MCLK_HALF = 4
) (
	// system clock and source reset
	input wire logic clk,
	input wire logic resetn,
	// link wires
	input wire logic master_clock,
	input wire logic bit_clock,
	input wire logic frame_clock,
	input wire logic [LINES-1:0] serial_data
);
	logic [7:0] cnt_r;
	logic [7:0] hi_r;
	logic [7:0] prev_r;
	logic [1:0] arm_r;
	logic [7:0] bhi_r;
	logic [7:0] mhi_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	// bit clocks per frame and in its high half; arm skips the partial first frame
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_r <= 8'h00;
			hi_r <= 8'h00;
			prev_r <= 8'h00;
			arm_r <= 2'h0;
		end else if ($rose(frame_clock)) begin
			cnt_r <= 8'h00;
			hi_r <= 8'h00;
			prev_r <= cnt_r;
			arm_r <= (arm_r == 2'h2) ? 2'h2 : arm_r + 2'h1;
		end else if ($rose(bit_clock)) begin
			cnt_r <= cnt_r + 8'h01;
			hi_r <= frame_clock ? hi_r + 8'h01 : hi_r;
		end
	end

	// length of the high phase of both clocks
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			bhi_r <= 8'h00;
			mhi_r <= 8'h00;
		end else begin
			bhi_r <= bit_clock ? bhi_r + 8'h01 : 8'h00;
			mhi_r <= master_clock ? mhi_r + 8'h01 : 8'h00;
		end
	end

	property p_frame_on_fall;
		$changed(frame_clock) |-> $fell(bit_clock);
	endproperty
	a_frame_on_fall: assert property (p_frame_on_fall) else $error("frame moved off a bit clock fall");
	property p_data_on_fall;
		$changed(serial_data) |-> $fell(bit_clock);
	endproperty
	a_data_on_fall: assert property (p_data_on_fall) else $error("data moved off a bit clock fall");
	property p_ratio_legal;
		$rose(frame_clock) && arm_r != 2'h0 |-> cnt_r == 8'd32 || cnt_r == 8'd48 || cnt_r == 8'd64;
	endproperty
	a_ratio_legal: assert property (p_ratio_legal) else $error("bit clocks per frame not 32/48/64");
	property p_ratio_steady;
		$rose(frame_clock) && arm_r == 2'h2 |-> cnt_r == prev_r;
	endproperty
	a_ratio_steady: assert property (p_ratio_steady) else $error("frame length changed while running");
	property p_duty_half;
		$rose(frame_clock) && arm_r != 2'h0 |-> cnt_r == {hi_r[6:0], 1'b0};
	endproperty
	a_duty_half: assert property (p_duty_half) else $error("frame clock not one slot per half");
	property p_slot_hold;
		$changed(frame_clock) |=> $stable(frame_clock) [*8];
	endproperty
	a_slot_hold: assert property (p_slot_hold) else $error("frame clock slot too short");
	property p_bclk_high;
		$fell(bit_clock) |-> bhi_r == BCLK_HALF;
	endproperty
	a_bclk_high: assert property (p_bclk_high) else $error("bit clock high phase wrong");
	property p_mclk_high;
		$fell(master_clock) |-> mhi_r == MCLK_HALF;
	endproperty
	a_mclk_high: assert property (p_mclk_high) else $error("master clock high phase wrong");

	c_frame_32: cover property ($rose(frame_clock) && arm_r == 2'h2 && cnt_r == 8'd32);
	c_frame_48: cover property ($rose(frame_clock) && arm_r == 2'h2 && cnt_r == 8'd48);
	c_frame_64: cover property ($rose(frame_clock) && arm_r == 2'h2 && cnt_r == 8'd64);
endmodule : audio_link_properties
`default_nettype wire

// *** audio_port_pkg.sv ***
/*
 * shared constants, types and helpers for the serial audio link:
 * framing, word length, rate classes, timing counts and the host register map.
 * assumes a 250 MHz system clock on both ends.
 */
package audio_port_pkg;
	// link geometry
	localparam int SAMPLE_W = 24;
	localparam int LINES = 2;

	typedef enum logic [1:0] {
		FRAMING_I2S = 2'h0,
		FRAMING_LEFT_ALIGNED = 2'h1,
		FRAMING_RIGHT_ALIGNED = 2'h2
	} framing_type;

	typedef enum logic [1:0] {
		WORD_16 = 2'h0,
		WORD_18 = 2'h1,
		WORD_20 = 2'h2,
		WORD_24 = 2'h3
	} word_len_type;

	typedef enum logic [1:0] {
		RATE_32K = 2'h0,
		RATE_NORMAL = 2'h1,
		RATE_DOUBLE = 2'h2,
		RATE_QUAD = 2'h3
	} rate_class_type;

	typedef enum logic [1:0] {
		RATIO_32 = 2'h0,
		RATIO_48 = 2'h1,
		RATIO_64 = 2'h2
	} ratio_type;

	// legal bit clocks per frame
	localparam logic [6:0] FRAME_BITS_32 = 7'h20;
	localparam logic [6:0] FRAME_BITS_48 = 7'h30;
	localparam logic [6:0] FRAME_BITS_64 = 7'h40;

	// clock and rate class boundaries
	localparam int CLK_FREQ_HZ = 250_000_000;
	localparam int RATE_EDGE_LOW_HZ = 40_000;
	localparam int RATE_EDGE_MID_HZ = 64_000;
	localparam int RATE_EDGE_HIGH_HZ = 128_000;
	localparam int FRAME_CYC_LOW = CLK_FREQ_HZ / RATE_EDGE_LOW_HZ;
	localparam int FRAME_CYC_MID = CLK_FREQ_HZ / RATE_EDGE_MID_HZ;
	localparam int FRAME_CYC_HIGH = CLK_FREQ_HZ / RATE_EDGE_HIGH_HZ;

	// master clock counts as missing after this long without an edge
	localparam int MCLK_TIMEOUT_NS = 200;
	localparam int MCLK_TIMEOUT_CYC = (CLK_FREQ_HZ / 1_000_000) * MCLK_TIMEOUT_NS / 1000;

	// modulator output multiples of the sample rate
	localparam logic [3:0] PWM_MULT_NORMAL = 4'h8;
	localparam logic [3:0] PWM_MULT_AM_0 = 4'h7;
	localparam logic [3:0] PWM_MULT_AM_1 = 4'h8;
	localparam logic [3:0] PWM_MULT_AM_2 = 4'h6;

	// host register map, word indices
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h1;
	localparam logic [3:0] REG_SAMPLE_BASE = 4'h2;
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_FRAMING_LSB = 1;
	localparam int CTRL_WORD_LSB = 3;
	localparam int CTRL_RATIO_LSB = 5;
	localparam int STATUS_NEED_BIT = 0;
	localparam int STATUS_ENABLE_BIT = 1;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0058;

	// host clock dividers, half periods in system clocks
	localparam int BCLK_HALF_DEFAULT = 16;
	localparam int MCLK_HALF_DEFAULT = 4;

	function automatic logic [4:0] word_bits(input word_len_type wl);
		case (wl)
			WORD_16: word_bits = 5'h10;
			WORD_18: word_bits = 5'h12;
			WORD_20: word_bits = 5'h14;
			default: word_bits = 5'h18;
		endcase
	endfunction : word_bits

	function automatic logic [5:0] slot_bits(input ratio_type r);
		case (r)
			RATIO_32: slot_bits = 6'h10;
			RATIO_48: slot_bits = 6'h18;
			default: slot_bits = 6'h20;
		endcase
	endfunction : slot_bits
endpackage : audio_port_pkg

// *** audio_receiver.sv ***
/*
 * serial audio receiver: deserialises the link on the bit clock, checks the
 * bit clock ratio, and hands each frame to the system clock domain together
 * with master clock supervision and rate classification.
 * assumes frame and data change on the falling bit clock edge and are stable
 * around the rising one; configuration inputs change only while idle.
 */
`timescale 1ns/100ps
`default_nettype none
// Operation
// - check bit clock is 32, 48 or 64 per frame
// - frame clock runs once per stereo pair
// - flag master clock loss, fall back to oscillator
// - classify rate as 32k, normal, double, quad
// - manual rate replaces detection when auto off
// - host sets rate manually for am/de-emphasis
// - am mode sets modulator multiple 7, 8, 6
// - accept 16-24 bit words, three framings
// - i2s left slot while frame low
// - i2s msb one bit after frame edge
// - msb first, sampled on rising bit clock
// - drop trailing bits past word length
// - aligned framings left slot while frame high
// - left aligned msb at frame edge
// - right aligned lsb just before frame edge
// - right aligned keeps only final word bits
// - samples are two's complement, msb first
// - 32 to 64 bit clocks per frame
module audio_receiver #(
	parameter int LINES = audio_port_pkg::LINES,
	parameter int FRAME_CYC_LOW = audio_port_pkg::FRAME_CYC_LOW,
	parameter int FRAME_CYC_MID = audio_port_pkg::FRAME_CYC_MID,
	parameter int FRAME_CYC_HIGH = audio_port_pkg::FRAME_CYC_HIGH
) (
	// system clock and reset
	input wire logic clk,
	input wire logic resetn,
	// link
	audio_link_if.device link,
	// configuration
	input wire audio_port_pkg::framing_type framing,
	input wire audio_port_pkg::word_len_type word_length,
	input wire logic auto_rate_enable,
	input wire audio_port_pkg::rate_class_type manual_rate,
	input wire logic am_avoid_enable,
	input wire logic [1:0] am_select,
	input wire logic deemph_enable,
	// samples
	output logic [LINES-1:0][audio_port_pkg::SAMPLE_W-1:0] left_sample,
	output logic [LINES-1:0][audio_port_pkg::SAMPLE_W-1:0] right_sample,
	output logic sample_valid,
	// status
	output audio_port_pkg::rate_class_type rate_class,
	output logic ratio_ok,
	output logic clock_source_osc,
	output logic [3:0] pwm_multiple
);
	localparam int SW = audio_port_pkg::SAMPLE_W;

	// move a captured word to the top of the 24-bit sample, zero below
	function automatic logic [SW-1:0] align_word(input logic [SW-1:0] sh, input logic [4:0] wl);
		align_word = sh << (5'(SW) - wl);
	endfunction : align_word

	// ---------------- link domain ----------------
	wire logic lclk = link.bit_clock;
	logic lrst_q1_r, lrst_q2_r;
	logic [3:0] cfg_q1_r, cfg_q2_r;
	logic frame_q_r, frame_d_r, slot_left_d_r;
	logic [LINES-1:0] data_q_r;
	logic [LINES-1:0][SW-1:0] sh_r, left_pend_r, left_hold_r, right_hold_r;
	logic [4:0] taken_r;
	logic frame_tog_r;
	logic [6:0] bclk_cnt_r;
	logic link_ratio_ok_r;

	// reset leaves the link domain only after two bit clock edges
	always_ff @(posedge lclk or negedge resetn) begin
		if (!resetn) begin
			lrst_q1_r <= 1'b0;
			lrst_q2_r <= 1'b0;
		end else begin
			lrst_q1_r <= 1'b1;
			lrst_q2_r <= lrst_q1_r;
		end
	end

	// framing and word length are quasi static; two flops are enough
	always_ff @(posedge lclk or negedge lrst_q2_r) begin
		if (!lrst_q2_r) begin
			cfg_q1_r <= 4'h0;
			cfg_q2_r <= 4'h0;
		end else begin
			cfg_q1_r <= {framing, word_length};
			cfg_q2_r <= cfg_q1_r;
		end
	end

	wire audio_port_pkg::framing_type lfram = audio_port_pkg::framing_type'(cfg_q2_r[3:2]);
	wire logic [4:0] lwl = audio_port_pkg::word_bits(audio_port_pkg::word_len_type'(cfg_q2_r[1:0]));
	wire logic is_i2s = (lfram == audio_port_pkg::FRAMING_I2S);
	wire logic is_right = (lfram == audio_port_pkg::FRAMING_RIGHT_ALIGNED);
	// i2s is treated as left aligned with the frame delayed one bit and inverted
	wire logic slot_left = is_i2s ? ~frame_d_r : frame_q_r;
	wire logic slot_edge = (slot_left != slot_left_d_r);
	wire logic frame_rise = frame_q_r & ~frame_d_r;

	// pins are sampled on the rising bit clock edge they are timed to
	always_ff @(posedge lclk or negedge lrst_q2_r) begin
		if (!lrst_q2_r) begin
			frame_q_r <= 1'b0;
			frame_d_r <= 1'b0;
			data_q_r <= '0;
			slot_left_d_r <= 1'b0;
		end else begin
			frame_q_r <= link.frame_clock;
			data_q_r <= link.serial_data;
			frame_d_r <= frame_q_r;
			slot_left_d_r <= slot_left;
		end
	end

	// shifter: msb first, trailing bits dropped, or all bits kept when right aligned
	always_ff @(posedge lclk or negedge lrst_q2_r) begin
		if (!lrst_q2_r) begin
			sh_r <= '0;
			taken_r <= 5'h0;
		end else if (slot_edge) begin
			for (int l = 0; l < LINES; l++) begin
				sh_r[l] <= {{(SW-1){1'b0}}, data_q_r[l]};
			end
			taken_r <= 5'h1;
		end else if (is_right || taken_r < lwl) begin
			for (int l = 0; l < LINES; l++) begin
				sh_r[l] <= {sh_r[l][SW-2:0], data_q_r[l]};
			end
			taken_r <= taken_r + 5'h1;
		end
	end

	// slot completion: hold a frame stable and toggle to announce it
	always_ff @(posedge lclk or negedge lrst_q2_r) begin
		if (!lrst_q2_r) begin
			left_pend_r <= '0;
			left_hold_r <= '0;
			right_hold_r <= '0;
			frame_tog_r <= 1'b0;
		end else if (slot_edge) begin
			for (int l = 0; l < LINES; l++) begin
				if (slot_left) begin
					right_hold_r[l] <= align_word(sh_r[l], lwl);
					left_hold_r[l] <= left_pend_r[l];
				end else begin
					left_pend_r[l] <= align_word(sh_r[l], lwl);
				end
			end
			if (slot_left) begin
				frame_tog_r <= ~frame_tog_r;
			end
		end
	end

	// bit clocks between frame rises, saturating; is what makes it land
	always_ff @(posedge lclk or negedge lrst_q2_r) begin
		if (!lrst_q2_r) begin
			bclk_cnt_r <= 7'h0;
			link_ratio_ok_r <= 1'b0;
		end else if (frame_rise) begin
			bclk_cnt_r <= 7'h1;
			link_ratio_ok_r <= (bclk_cnt_r == audio_port_pkg::FRAME_BITS_32) ||
				(bclk_cnt_r == audio_port_pkg::FRAME_BITS_48) ||
				(bclk_cnt_r == audio_port_pkg::FRAME_BITS_64);
		end else if (bclk_cnt_r != 7'h7f) begin
			bclk_cnt_r <= bclk_cnt_r + 7'h1;
		end
	end

	// ---------------- system domain ----------------
	logic tog_q1_r, tog_q2_r, tog_q3_r;
	logic rok_q1_r, rok_q2_r;
	logic mck_q1_r, mck_q2_r, mck_q3_r;
	logic [15:0] period_cnt_r;
	logic [7:0] mck_idle_r;
	audio_port_pkg::rate_class_type detected_r;
	wire logic frame_event = tog_q2_r ^ tog_q3_r;

	// crossings: frame toggle and master clock take three flops, the ratio level two
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tog_q1_r <= 1'b0;
			tog_q2_r <= 1'b0;
			tog_q3_r <= 1'b0;
			rok_q1_r <= 1'b0;
			rok_q2_r <= 1'b0;
			mck_q1_r <= 1'b0;
			mck_q2_r <= 1'b0;
			mck_q3_r <= 1'b0;
		end else begin
			tog_q1_r <= frame_tog_r;
			tog_q2_r <= tog_q1_r;
			tog_q3_r <= tog_q2_r;
			rok_q1_r <= link_ratio_ok_r;
			rok_q2_r <= rok_q1_r;
			mck_q1_r <= link.master_clock;
			mck_q2_r <= mck_q1_r;
			mck_q3_r <= mck_q2_r;
		end
	end

	// holds are stable for a whole slot, so the toggle guards them
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			left_sample <= '0;
			right_sample <= '0;
			sample_valid <= 1'b0;
		end else begin
			sample_valid <= frame_event;
			if (frame_event) begin
				left_sample <= left_hold_r;
				right_sample <= right_hold_r;
			end
		end
	end

	// frame period in system clocks selects the rate class
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			period_cnt_r <= 16'h0;
			detected_r <= audio_port_pkg::RATE_NORMAL;
		end else if (frame_event) begin
			period_cnt_r <= 16'h1;
			if (period_cnt_r > 16'(FRAME_CYC_LOW)) begin
				detected_r <= audio_port_pkg::RATE_32K;
			end else if (period_cnt_r > 16'(FRAME_CYC_MID)) begin
				detected_r <= audio_port_pkg::RATE_NORMAL;
			end else if (period_cnt_r > 16'(FRAME_CYC_HIGH)) begin
				detected_r <= audio_port_pkg::RATE_DOUBLE;
			end else begin
				detected_r <= audio_port_pkg::RATE_QUAD;
			end
		end else if (period_cnt_r != 16'hffff) begin
			period_cnt_r <= period_cnt_r + 16'h1;
		end
	end

	// am and de-emphasis always run from the manual setting, never a guess
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rate_class <= audio_port_pkg::RATE_NORMAL;
			ratio_ok <= 1'b0;
		end else begin
			ratio_ok <= rok_q2_r;
			if (auto_rate_enable && !am_avoid_enable && !deemph_enable) begin
				rate_class <= detected_r;
			end else begin
				rate_class <= manual_rate;
			end
		end
	end

	// master clock supervision; a timeout hands processing to the oscillator
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mck_idle_r <= 8'h0;
			clock_source_osc <= 1'b1;
		end else if (mck_q2_r != mck_q3_r) begin
			mck_idle_r <= 8'h0;
			clock_source_osc <= 1'b0;
		end else if (mck_idle_r >= 8'(audio_port_pkg::MCLK_TIMEOUT_CYC)) begin
			clock_source_osc <= 1'b1;
		end else begin
			mck_idle_r <= mck_idle_r + 8'h1;
		end
	end

	// modulator multiple follows the am setting
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pwm_multiple <= audio_port_pkg::PWM_MULT_NORMAL;
		end else if (!am_avoid_enable) begin
			pwm_multiple <= audio_port_pkg::PWM_MULT_NORMAL;
		end else begin
			case (am_select)
				2'h0: pwm_multiple <= audio_port_pkg::PWM_MULT_AM_0;
				2'h1: pwm_multiple <= audio_port_pkg::PWM_MULT_AM_1;
				default: pwm_multiple <= audio_port_pkg::PWM_MULT_AM_2;
			endcase
		end
	end
endmodule : audio_receiver
`default_nettype wire

// *** audio_source.sv ***
/*
 * clock-driving audio source: divides the system clock into master and bit
 * clocks and serialises register-loaded samples in the chosen framing.
 * assumes software writes samples once per frame, answering the need flag.
 */
`timescale 1ns/100ps
`default_nettype none
module audio_source #(
	parameter int LINES = audio_port_pkg::LINES,
	parameter int BCLK_HALF = audio_port_pkg::BCLK_HALF_DEFAULT,
	parameter int MCLK_HALF = audio_port_pkg::MCLK_HALF_DEFAULT
) (
	// system clock and reset
	input wire logic clk,
	input wire logic resetn,
	// register port
	input wire logic [3:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	// link
	audio_link_if.host link
);
	localparam int SW = audio_port_pkg::SAMPLE_W;
	localparam logic [3:0] LAST_SAMPLE = audio_port_pkg::REG_SAMPLE_BASE + 4'(2 * LINES - 1);

	logic [31:0] ctrl_r;
	logic [SW-1:0] sample_r [2*LINES];
	logic [SW-1:0] shadow_r [2*LINES];
	logic need_r;
	logic [7:0] mck_cnt_r, bck_cnt_r;
	logic mclk_r, bclk_r, frame_r;
	logic [5:0] pos_r;
	logic right_r, prev_bit_r;
	logic [LINES-1:0] data_r, prev_r;

	wire logic enable = ctrl_r[audio_port_pkg::CTRL_ENABLE_BIT];
	wire audio_port_pkg::framing_type fram =
		audio_port_pkg::framing_type'(ctrl_r[audio_port_pkg::CTRL_FRAMING_LSB +: 2]);
	wire logic [4:0] wl = audio_port_pkg::word_bits(
		audio_port_pkg::word_len_type'(ctrl_r[audio_port_pkg::CTRL_WORD_LSB +: 2]));
	wire logic [5:0] slot = audio_port_pkg::slot_bits(
		audio_port_pkg::ratio_type'(ctrl_r[audio_port_pkg::CTRL_RATIO_LSB +: 2]));
	wire logic bck_fall = enable && bclk_r && (bck_cnt_r == 8'(BCLK_HALF - 1));
	wire logic wrap = (pos_r >= slot - 6'h1);
	wire logic [5:0] npos = wrap ? 6'h0 : pos_r + 6'h1;
	wire logic nright = wrap ? ~right_r : right_r;
	wire logic [5:0] rstart = slot - 6'(wl);

	// register writes; a frame start sets need, last sample write clears it, set wins
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_r <= audio_port_pkg::CTRL_RESET;
			for (int i = 0; i < 2 * LINES; i++) begin
				sample_r[i] <= '0;
			end
			need_r <= 1'b0;
		end else begin
			if (wr && addr == audio_port_pkg::REG_CTRL) begin
				ctrl_r <= wdata;
			end
			for (int i = 0; i < 2 * LINES; i++) begin
				if (wr && addr == audio_port_pkg::REG_SAMPLE_BASE + 4'(i)) begin
					sample_r[i] <= wdata[SW-1:0];
				end
			end
			if (bck_fall && wrap && right_r) begin
				need_r <= 1'b1;
			end else if (wr && addr == LAST_SAMPLE) begin
				need_r <= 1'b0;
			end
		end
	end

	// read data stands in the cycle after the strobe only; unmapped reads zero
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata <= 32'h0;
		end else begin
			rdata <= 32'h0;
			if (rd) begin
				if (addr == audio_port_pkg::REG_CTRL) begin
					rdata <= ctrl_r;
				end else if (addr == audio_port_pkg::REG_STATUS) begin
					rdata[audio_port_pkg::STATUS_NEED_BIT] <= need_r;
					rdata[audio_port_pkg::STATUS_ENABLE_BIT] <= enable;
				end
				for (int i = 0; i < 2 * LINES; i++) begin
					if (addr == audio_port_pkg::REG_SAMPLE_BASE + 4'(i)) begin
						rdata <= {{(32-SW){sample_r[i][SW-1]}}, sample_r[i]};
					end
				end
			end
		end
	end

	// master clock runs free after reset, even while disabled; it stops only while the source is held in reset
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mck_cnt_r <= 8'h0;
			mclk_r <= 1'b0;
		end else if (mck_cnt_r == 8'(MCLK_HALF - 1)) begin
			mck_cnt_r <= 8'h0;
			mclk_r <= ~mclk_r;
		end else begin
			mck_cnt_r <= mck_cnt_r + 8'h1;
		end
	end

	// bit clock stands low while disabled
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			bck_cnt_r <= 8'h0;
			bclk_r <= 1'b0;
		end else if (!enable) begin
			bck_cnt_r <= 8'h0;
			bclk_r <= 1'b0;
		end else if (bck_cnt_r == 8'(BCLK_HALF - 1)) begin
			bck_cnt_r <= 8'h0;
			bclk_r <= ~bclk_r;
		end else begin
			bck_cnt_r <= bck_cnt_r + 8'h1;
		end
	end

	// frame and data move on the falling edge, msb first, left slot first
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pos_r <= 6'h3f;
			right_r <= 1'b1;
			frame_r <= 1'b0;
			data_r <= '0;
			prev_r <= '0;
			for (int i = 0; i < 2 * LINES; i++) begin
				shadow_r[i] <= '0;
			end
		end else if (!enable) begin
			pos_r <= 6'h3f;
			right_r <= 1'b1;
		end else if (bck_fall) begin
			pos_r <= npos;
			right_r <= nright;
			frame_r <= (fram == audio_port_pkg::FRAMING_I2S) ? nright : ~nright;
			if (wrap && right_r) begin
				for (int i = 0; i < 2 * LINES; i++) begin
					shadow_r[i] <= sample_r[i];
				end
			end
			for (int l = 0; l < LINES; l++) begin
				logic [SW-1:0] w;
				logic b;
				w = (wrap && right_r) ? sample_r[2*l] : shadow_r[2*l + (nright ? 1 : 0)];
				b = 1'b0;
				if (fram == audio_port_pkg::FRAMING_RIGHT_ALIGNED) begin
					if (npos >= rstart) begin
						b = w[5'(SW - 1) - 5'(npos - rstart)];
					end
				end else if (npos < 6'(wl)) begin
					b = w[5'(SW - 1) - 5'(npos)];
				end
				prev_r[l] <= b;
				data_r[l] <= (fram == audio_port_pkg::FRAMING_I2S) ? prev_r[l] : b;
			end
		end
	end

	assign link.master_clock = mclk_r;
	assign link.bit_clock = bclk_r;
	assign link.frame_clock = frame_r;
	assign link.serial_data = data_r;
endmodule : audio_source
`default_nettype wire

// *** tb_serial_audio_input_port.sv ***
/*
 * testbench: source and receiver joined by the link; samples written over the
 * register port must arrive at the receiver in every framing and frame ratio.
 * assumes the source stops the link while held in its own reset.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_serial_audio_input_port;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic src_resetn = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [31:0] wdata = 32'h0000_0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata;
	audio_port_pkg::framing_type framing = audio_port_pkg::FRAMING_I2S;
	audio_port_pkg::word_len_type word_length = audio_port_pkg::WORD_24;
	logic auto_rate_enable = 1'b1;
	audio_port_pkg::rate_class_type manual_rate = audio_port_pkg::RATE_QUAD;
	logic am_avoid_enable = 1'b0;
	logic [1:0] am_select = 2'h0;
	logic deemph_enable = 1'b0;
	logic [audio_port_pkg::LINES-1:0][audio_port_pkg::SAMPLE_W-1:0] left_sample;
	logic [audio_port_pkg::LINES-1:0][audio_port_pkg::SAMPLE_W-1:0] right_sample;
	logic sample_valid;
	audio_port_pkg::rate_class_type rate_class;
	logic ratio_ok;
	logic clock_source_osc;
	logic [3:0] pwm_multiple;
	int n_fail = 0;
	int checks = 0;
	int cyc = 0;
	logic [23:0] lv [2];
	logic [23:0] rv [2];
	logic [31:0] got;
	logic [4:0] wtab [4] = '{5'h10, 5'h12, 5'h14, 5'h18};
	logic [3:0] ptab [4] = '{4'h7, 4'h8, 4'h6, 4'h6};
	// frame lengths 1024/1536/2048 clk fall in distinct classes with these bounds
	logic [1:0] rtab [3] = '{2'h2, 2'h1, 2'h0};

	// link width and clock halves stay at their defaults; only the rate bounds are scaled
	audio_link_if link_if_inst ();
	audio_source audio_source_inst (.clk(clk),
		.resetn(src_resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.link(link_if_inst));
	audio_receiver #(.FRAME_CYC_LOW(1800), .FRAME_CYC_MID(1280),
		.FRAME_CYC_HIGH(1000)) audio_receiver_inst (.clk(clk), .resetn(resetn),
		.link(link_if_inst), .framing(framing), .word_length(word_length),
		.auto_rate_enable(auto_rate_enable), .manual_rate(manual_rate),
		.am_avoid_enable(am_avoid_enable), .am_select(am_select),
		.deemph_enable(deemph_enable), .left_sample(left_sample), .right_sample(right_sample),
		.sample_valid(sample_valid), .rate_class(rate_class), .ratio_ok(ratio_ok),
		.clock_source_osc(clock_source_osc), .pwm_multiple(pwm_multiple));
	audio_link_properties props_inst (.clk(clk),
		.resetn(src_resetn), .master_clock(link_if_inst.master_clock),
		.bit_clock(link_if_inst.bit_clock), .frame_clock(link_if_inst.frame_clock),
		.serial_data(link_if_inst.serial_data));

	// 250 MHz system clock
	initial begin
		forever #2 clk = ~clk;
	end

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR t=%0t %s: got %h expected %h", $time, what, seen, exp);
		end
	endtask : chk

	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	// read data stands only in the cycle after the strobe
	task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : rd_reg

	// the valid strobe must drop again after exactly one cycle
	task automatic wait_valid();
		@(posedge clk);
		#1;
		while (sample_valid !== 1'b1) begin
			@(posedge clk);
			#1;
		end
		@(posedge clk);
		#1 chk(sample_valid, 1'b0, "valid pulse length");
	endtask : wait_valid

	// msb of the left word on line 0, at the bit position its framing places it
	task automatic check_wire(input int f, input int slot, input int w, input logic msb);
		int n;
		if (f == 0) @(negedge link_if_inst.frame_clock);
		else @(posedge link_if_inst.frame_clock);
		n = (f == 0) ? 2 : (f == 2) ? slot - w + 1 : 1;
		repeat (n) @(posedge link_if_inst.bit_clock);
		chk(link_if_inst.serial_data[0], msb, "left msb on wire");
	endtask : check_wire

	task automatic run_cfg(input int f, input int r);
		audio_port_pkg::word_len_type wl;
		logic [31:0] mask;
		wl = (r == 0) ? audio_port_pkg::WORD_16 : audio_port_pkg::word_len_type'((f + r) % 4);
		mask = ~((32'h1 << (24 - wtab[wl])) - 32'h1);
		@(posedge clk);
		src_resetn <= 1'b0;
		framing <= audio_port_pkg::framing_type'(f);
		word_length <= wl;
		repeat (80) @(posedge clk);
		chk(clock_source_osc, 1'b1, "oscillator fallback");
		src_resetn <= 1'b1;
		for (int l = 0; l < 2; l++) begin
			lv[l] = (24'h9a5c3f ^ 24'((f * 16 + r * 4 + l) << 12)) & mask[23:0];
			rv[l] = ~lv[l] & mask[23:0];
			wr_reg(4'(2 + 2 * l), {8'h00, lv[l]});
			wr_reg(4'(3 + 2 * l), {8'h00, rv[l]});
		end
		wr_reg(audio_port_pkg::REG_CTRL, 32'(1 + f * 2 + int'(wl) * 8 + r * 32));
		check_wire(f, 16 + 8 * r, int'(wtab[wl]), lv[0][23]);
		wait_valid();
		wait_valid();
		for (int l = 0; l < 2; l++) begin
			chk(left_sample[l], lv[l], "left sample");
			chk(right_sample[l], rv[l], "right sample");
		end
		chk(ratio_ok, 1'b1, "ratio flag");
		chk(clock_source_osc, 1'b0, "master clock back");
		chk(rate_class, rtab[r], "auto rate class");
		$display("test framing %0d ratio %0d done", f, r);
	endtask : run_cfg

	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 100000) begin
			n_fail++;
			$display("ERROR t=%0t run did not finish", $time);
			end_of_test();
		end
	end

	initial begin
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		src_resetn <= 1'b1;
		rd_reg(audio_port_pkg::REG_CTRL, got);
		chk(got, audio_port_pkg::CTRL_RESET, "control reset value");
		rd_reg(4'hf, got);
		chk(got, 32'h0000_0000, "unmapped read");
		wr_reg(4'h2, 32'h0080_0000);
		rd_reg(4'h2, got);
		chk(got, 32'hff80_0000, "sign extended read");
		$display("test registers done");
		for (int f = 0; f < 3; f++) begin
			for (int r = 0; r < 3; r++) begin
				run_cfg(f, r);
			end
		end
		// rate and modulator controls while the link keeps running
		auto_rate_enable <= 1'b0;
		wait_valid();
		wait_valid();
		chk(rate_class, audio_port_pkg::RATE_QUAD, "manual rate");
		auto_rate_enable <= 1'b1;
		deemph_enable <= 1'b1;
		wait_valid();
		wait_valid();
		chk(rate_class, audio_port_pkg::RATE_QUAD, "de-emphasis rate");
		deemph_enable <= 1'b0;
		am_avoid_enable <= 1'b1;
		for (int s = 0; s < 4; s++) begin
			am_select <= 2'(s);
			wait_valid();
			chk(pwm_multiple, ptab[s], "am multiple");
			chk(rate_class, audio_port_pkg::RATE_QUAD, "am rate");
		end
		am_avoid_enable <= 1'b0;
		wait_valid();
		chk(pwm_multiple, audio_port_pkg::PWM_MULT_NORMAL, "normal multiple");
		chk(rate_class, rtab[2], "auto rate restored");
		$display("test rate controls done");
		end_of_test();
	end
endmodule : tb_serial_audio_input_port
`default_nettype wire
